// [verilog/mgmr_pkg.sv]
`default_nettype none
package mgmr_pkg;
   // register addresses on the serial host port
   localparam logic [6:0] ADDR_GAIN_A = 7'h69;
   localparam logic [6:0] ADDR_GAIN_B = 7'h6A;
   localparam logic [6:0] ADDR_RATE_LO = 7'h6F;
   localparam logic [6:0] ADDR_MOD_A = 7'h70;
   localparam logic [6:0] ADDR_MOD_B = 7'h71;
   localparam logic [6:0] ADDR_DEV_LO = 7'h72;
   localparam logic [6:0] ADDR_OFS_LO = 7'h73;
   localparam logic [6:0] ADDR_OFS_HI = 7'h74;
   // reset values
   localparam logic [7:0] RST_GAIN_A = 8'h20;
   localparam logic [7:0] RST_GAIN_B = 8'h00;
   localparam logic [7:0] RST_RATE_LO = 8'h3D;
   localparam logic [7:0] RST_MOD_A = 8'h00;
   localparam logic [7:0] RST_MOD_B = 8'h00;
   localparam logic [7:0] RST_DEV_LO = 8'h20;
   localparam logic [7:0] RST_OFS_LO = 8'h00;
   localparam logic [7:0] RST_OFS_HI = 8'h00;
   // field positions
   localparam int GA_AGCEN = 5;
   localparam int GA_LNA = 4;
   localparam int GB_IGNPRE = 7;
   localparam int GB_SLOW = 6;
   localparam int GB_COMP_HI = 5;
   localparam int GB_COMP_LO = 2;
   localparam int MA_RES5 = 5;
   localparam int MA_PHPWDN = 4;
   localparam int MA_MANPOL = 3;
   localparam int MA_MANINV = 2;
   localparam int MA_MANCH = 1;
   localparam int MA_WHITE = 0;
   localparam int MB_RXINV = 3;
   localparam int MB_DEVMSB = 2;
   // gain figures in dB, and the top amplifier code
   localparam logic [4:0] LNA_DB_MIN = 5'h05;
   localparam logic [4:0] LNA_DB_MAX = 5'h19;
   localparam logic [3:0] PGA_MAX_CODE = 4'h5;
   localparam logic [4:0] PGA_DB_MAX = 5'h18;
   // frequency steps: deviation in Hz, offset in quarter Hz
   localparam logic [9:0] DEV_STEP_HZ = 10'h271;
   localparam logic [10:0] OFS_STEP_QHZ = 11'h271;
   // gain loop timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int AGC_STEP_NS = 1000;
   localparam int AGC_STEP_CYC = (AGC_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] AGC_SLOW_LAST = 3'h7;

   typedef enum logic [1:0] {
      MGMR_OFF = 2'b00,
      MGMR_TRACK = 2'b01,
      MGMR_LOCK = 2'b10
   } mgmr_state_t;

   function automatic logic [4:0] mgmr_pga_db(input logic [3:0] code);
      logic [4:0] db;
      db = PGA_DB_MAX;
      unique case (code)
         4'h0: db = 5'h00;
         4'h1: db = 5'h03;
         4'h2: db = 5'h06;
         4'h3: db = 5'h0C;
         4'h4: db = 5'h12;
         default: db = PGA_DB_MAX;
      endcase
      return db;
   endfunction
endpackage
`default_nettype wire

// [verilog/mgmr_gain_loop.sv]
`timescale 1ns/1ps
`default_nettype none
module mgmr_gain_loop (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic en,
   input wire logic too_high,
   input wire logic too_low,
   input wire logic preamble_det,
   input wire logic ignore_preamble,
   input wire logic slow,
   output logic lna_high,
   output logic [3:0] pga
);
   logic [5:0] div;
   logic [2:0] slow_cnt;
   logic step_tick;
   logic up_ok;
   mgmr_pkg::mgmr_state_t state;

   assign step_tick = (div == 6'(mgmr_pkg::AGC_STEP_CYC - 1));
   assign up_ok = !slow || (slow_cnt == mgmr_pkg::AGC_SLOW_LAST);

   always_ff @(posedge clk) begin
      if (!rst_b || step_tick) begin
         div <= 6'h00;
      end else begin
         div <= div + 6'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         slow_cnt <= 3'h0;
      end else if (step_tick) begin
         slow_cnt <= slow_cnt + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= mgmr_pkg::MGMR_OFF;
      end else begin
         unique case (state)
            mgmr_pkg::MGMR_OFF: if (en) state <= mgmr_pkg::MGMR_TRACK;
            mgmr_pkg::MGMR_TRACK: begin
               if (!en) state <= mgmr_pkg::MGMR_OFF;
               else if (preamble_det && !ignore_preamble) state <= mgmr_pkg::MGMR_LOCK;
            end
            mgmr_pkg::MGMR_LOCK: begin
               if (!en) state <= mgmr_pkg::MGMR_OFF;
               else if (!preamble_det || ignore_preamble) state <= mgmr_pkg::MGMR_TRACK;
            end
            default: state <= mgmr_pkg::MGMR_OFF;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         lna_high <= 1'b1;
         pga <= mgmr_pkg::PGA_MAX_CODE;
      end else if (state == mgmr_pkg::MGMR_TRACK && step_tick) begin
         if (too_high) begin
            if (pga != 4'h0) begin
               pga <= pga - 4'h1;
            end else if (lna_high) begin
               lna_high <= 1'b0;
               pga <= mgmr_pkg::PGA_MAX_CODE;
            end
         end else if (too_low && up_ok) begin
            if (pga < mgmr_pkg::PGA_MAX_CODE) begin
               pga <= pga + 4'h1;
            end else if (!lna_high) begin
               lna_high <= 1'b1;
               pga <= 4'h0;
            end
         end
      end
   end

   a_lock_holds: assert property (@(posedge clk) disable iff (!rst_b)
      (state == mgmr_pkg::MGMR_LOCK) |=> $stable({lna_high, pga}))
      else $error("gain moved while locked on preamble");

   a_slow_rise: assert property (@(posedge clk) disable iff (!rst_b)
      (slow && $past(slow) && (pga > $past(pga)) && lna_high == $past(lna_high))
      |-> $past(slow_cnt) == mgmr_pkg::AGC_SLOW_LAST)
      else $error("slow gain increase stepped early");
endmodule // mgmr_gain_loop
`default_nettype wire

// [verilog/mgmr_freq_calc.sv]
`timescale 1ns/1ps
`default_nettype none
module mgmr_freq_calc (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [8:0] deviation_setting,
   input wire logic [9:0] offset_setting,
   input wire logic band_high,
   output logic [18:0] dev_hz,
   output logic signed [21:0] ofs_qhz
);
   logic [10:0] step;

   assign step = band_high ? {mgmr_pkg::OFS_STEP_QHZ[9:0], 1'b0} : mgmr_pkg::OFS_STEP_QHZ;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dev_hz <= 19'h00000;
      end else begin
         dev_hz <= {10'h000, deviation_setting} * {9'h000, mgmr_pkg::DEV_STEP_HZ};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ofs_qhz <= 22'sh000000;
      end else begin
         ofs_qhz <= $signed({{12{offset_setting[9]}}, offset_setting})
                    * $signed({11'h000, step});
      end
   end

   a_dev_scale: assert property (@(posedge clk) disable iff (!rst_b)
      $past(rst_b) |-> dev_hz == 19'($past(deviation_setting) * 625))
      else $error("deviation not 625 Hz per step");

   a_ofs_band: assert property (@(posedge clk) disable iff (!rst_b)
      ($past(rst_b) && $past(band_high) && $past(offset_setting) == 10'h001)
      |-> ofs_qhz == 22'sd1250)
      else $error("offset step not doubled in high band");
endmodule // mgmr_freq_calc
`default_nettype wire

// [verilog/mgmr_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module mgmr_regs (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic [6:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic AGC_TOO_HIGH,
   input wire logic AGC_TOO_LOW,
   input wire logic PREAMBLE_DET,
   input wire logic [7:0] RSSI_IN,
   input wire logic [9:0] AFC_RESULT,
   input wire logic BAND_HIGH,
   input wire logic LOW_POWER_MODE,
   output logic LNA_GAIN_HIGH,
   output logic [3:0] PGA_GAIN,
   output logic [4:0] LNA_GAIN_DB,
   output logic [4:0] PGA_GAIN_DB,
   output logic [1:0] PGA_WINDOW_ADJ,
   output logic [7:0] RSSI_SMOOTH,
   output logic [7:0] DATA_RATE_LOW,
   output logic MANCH_EN,
   output logic MANCH_INV,
   output logic TX_PREAMBLE_BIT,
   output logic WHITEN_EN,
   output logic RX_DATA_INV,
   output logic PH_POWER_DOWN,
   output logic [18:0] DEVIATION_HZ,
   output logic signed [21:0] OFFSET_QHZ
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);

   // stored register fields
   logic agc_en;
   logic man_lna;
   logic [3:0] man_pga;
   logic [7:0] gain_b;
   logic [7:0] rate_lo;
   logic mod_a_res5;
   logic [4:0] mod_a;
   logic rx_inv;
   logic dev_msb;
   logic [7:0] dev_lo;
   logic [7:0] ofs_lo;
   logic [1:0] ofs_hi;

   // loop and derived signals
   logic loop_lna;
   logic [3:0] loop_pga;
   logic next_lna;
   logic [3:0] next_pga;
   logic [3:0] comp;
   logic [7:0] next_rdata;
   logic wr_hit;
   logic [8:0] deviation_setting;
   logic [9:0] offset_setting;

   assign wr_hit = REG_WR;
   assign comp = gain_b[mgmr_pkg::GB_COMP_HI:mgmr_pkg::GB_COMP_LO];
   assign deviation_setting = {dev_msb, dev_lo};
   assign offset_setting = {ofs_hi, ofs_lo};

   // gain loop override a
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         agc_en <= mgmr_pkg::RST_GAIN_A[mgmr_pkg::GA_AGCEN];
         man_lna <= mgmr_pkg::RST_GAIN_A[mgmr_pkg::GA_LNA];
         man_pga <= mgmr_pkg::RST_GAIN_A[3:0];
      end else if (wr_hit && REG_ADDR == mgmr_pkg::ADDR_GAIN_A) begin
         agc_en <= REG_WDATA[mgmr_pkg::GA_AGCEN];
         man_lna <= REG_WDATA[mgmr_pkg::GA_LNA];
         man_pga <= REG_WDATA[3:0];
      end
   end

   // gain loop override b
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         gain_b <= mgmr_pkg::RST_GAIN_B;
      end else if (wr_hit && REG_ADDR == mgmr_pkg::ADDR_GAIN_B) begin
         gain_b <= REG_WDATA;
      end
   end

   // data rate low byte
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         rate_lo <= mgmr_pkg::RST_RATE_LO;
      end else if (wr_hit && REG_ADDR == mgmr_pkg::ADDR_RATE_LO) begin
         rate_lo <= REG_WDATA;
      end
   end

   // modulation control a, bits 7:6 read only
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         mod_a_res5 <= mgmr_pkg::RST_MOD_A[mgmr_pkg::MA_RES5];
         mod_a <= mgmr_pkg::RST_MOD_A[4:0];
      end else if (wr_hit && REG_ADDR == mgmr_pkg::ADDR_MOD_A) begin
         mod_a_res5 <= REG_WDATA[mgmr_pkg::MA_RES5];
         mod_a <= REG_WDATA[4:0];
      end
   end

   // modulation control b, only bits 3:2 stored
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         rx_inv <= mgmr_pkg::RST_MOD_B[mgmr_pkg::MB_RXINV];
         dev_msb <= mgmr_pkg::RST_MOD_B[mgmr_pkg::MB_DEVMSB];
      end else if (wr_hit && REG_ADDR == mgmr_pkg::ADDR_MOD_B) begin
         rx_inv <= REG_WDATA[mgmr_pkg::MB_RXINV];
         dev_msb <= REG_WDATA[mgmr_pkg::MB_DEVMSB];
      end
   end

   // deviation low byte
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         dev_lo <= mgmr_pkg::RST_DEV_LO;
      end else if (wr_hit && REG_ADDR == mgmr_pkg::ADDR_DEV_LO) begin
         dev_lo <= REG_WDATA;
      end
   end

   // written offset, never read back
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         ofs_lo <= mgmr_pkg::RST_OFS_LO;
         ofs_hi <= mgmr_pkg::RST_OFS_HI[1:0];
      end else if (wr_hit && REG_ADDR == mgmr_pkg::ADDR_OFS_LO) begin
         ofs_lo <= REG_WDATA;
      end else if (wr_hit && REG_ADDR == mgmr_pkg::ADDR_OFS_HI) begin
         ofs_hi <= REG_WDATA[1:0];
      end
   end

   // read mux
   always_comb begin
      next_rdata = 8'h00;
      unique case (REG_ADDR)
         mgmr_pkg::ADDR_GAIN_A: begin
            next_rdata[mgmr_pkg::GA_AGCEN] = agc_en;
            next_rdata[4:0] = agc_en ? {loop_lna, loop_pga} : {man_lna, man_pga};
         end
         mgmr_pkg::ADDR_GAIN_B: next_rdata = gain_b;
         mgmr_pkg::ADDR_RATE_LO: next_rdata = rate_lo;
         mgmr_pkg::ADDR_MOD_A: next_rdata = {2'b00, mod_a_res5, mod_a};
         mgmr_pkg::ADDR_MOD_B: next_rdata = {4'h0, rx_inv, dev_msb, 2'b00};
         mgmr_pkg::ADDR_DEV_LO: next_rdata = dev_lo;
         mgmr_pkg::ADDR_OFS_LO: next_rdata = AFC_RESULT[7:0];
         mgmr_pkg::ADDR_OFS_HI: next_rdata = {6'h00, AFC_RESULT[9:8]};
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         REG_RDATA <= 8'h00;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_RD;
         if (REG_RD) begin
            REG_RDATA <= next_rdata;
         end
      end
   end

   mgmr_gain_loop u_loop (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .en(agc_en),
      .too_high(AGC_TOO_HIGH),
      .too_low(AGC_TOO_LOW),
      .preamble_det(PREAMBLE_DET),
      .ignore_preamble(gain_b[mgmr_pkg::GB_IGNPRE]),
      .slow(gain_b[mgmr_pkg::GB_SLOW]),
      .lna_high(loop_lna),
      .pga(loop_pga)
   );

   mgmr_freq_calc u_freq (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .deviation_setting(deviation_setting),
      .offset_setting(offset_setting),
      .band_high(BAND_HIGH),
      .dev_hz(DEVIATION_HZ),
      .ofs_qhz(OFFSET_QHZ)
   );

   // applied gain and its value in dB
   assign next_lna = agc_en ? loop_lna : man_lna;
   assign next_pga = agc_en ? loop_pga : man_pga;

   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         LNA_GAIN_HIGH <= 1'b0;
         PGA_GAIN <= 4'h0;
         LNA_GAIN_DB <= mgmr_pkg::LNA_DB_MIN;
         PGA_GAIN_DB <= 5'h00;
      end else begin
         LNA_GAIN_HIGH <= next_lna;
         PGA_GAIN <= next_pga;
         LNA_GAIN_DB <= next_lna ? mgmr_pkg::LNA_DB_MAX : mgmr_pkg::LNA_DB_MIN;
         PGA_GAIN_DB <= mgmr_pkg::mgmr_pga_db(next_pga);
      end
   end

   // strength reading corrected while the front gain is high
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         RSSI_SMOOTH <= 8'h00;
      end else if (next_lna) begin
         RSSI_SMOOTH <= (RSSI_IN > {4'h0, comp}) ? RSSI_IN - {4'h0, comp} : 8'h00;
      end else begin
         RSSI_SMOOTH <= RSSI_IN;
      end
   end

   // modem control outputs
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         PGA_WINDOW_ADJ <= 2'b00;
         DATA_RATE_LOW <= mgmr_pkg::RST_RATE_LO;
         MANCH_EN <= 1'b0;
         MANCH_INV <= 1'b0;
         TX_PREAMBLE_BIT <= 1'b0;
         WHITEN_EN <= 1'b0;
         RX_DATA_INV <= 1'b0;
         PH_POWER_DOWN <= 1'b0;
      end else begin
         PGA_WINDOW_ADJ <= gain_b[1:0];
         DATA_RATE_LOW <= rate_lo;
         MANCH_EN <= mod_a[mgmr_pkg::MA_MANCH];
         MANCH_INV <= mod_a[mgmr_pkg::MA_MANCH] && mod_a[mgmr_pkg::MA_MANINV];
         TX_PREAMBLE_BIT <= mod_a[mgmr_pkg::MA_MANCH] && mod_a[mgmr_pkg::MA_MANPOL];
         WHITEN_EN <= mod_a[mgmr_pkg::MA_WHITE];
         RX_DATA_INV <= rx_inv;
         PH_POWER_DOWN <= mod_a[mgmr_pkg::MA_PHPWDN] && LOW_POWER_MODE;
      end
   end

   sequence s_write_gain;
      REG_WR && REG_ADDR == mgmr_pkg::ADDR_GAIN_A && !REG_WDATA[mgmr_pkg::GA_AGCEN];
   endsequence

   sequence s_read_ofs;
      REG_RD && REG_ADDR == mgmr_pkg::ADDR_OFS_LO;
   endsequence

   a_manual_gain: assert property (s_write_gain ##1 (!REG_WR) |=>
      LNA_GAIN_HIGH == $past(REG_WDATA[4], 2) && PGA_GAIN == $past(REG_WDATA[3:0], 2))
      else $error("manual gain write not applied");

   a_auto_read: assert property ((REG_RD && REG_ADDR == mgmr_pkg::ADDR_GAIN_A && agc_en)
      |=> REG_RVALID && REG_RDATA[4:0] == $past({loop_lna, loop_pga}))
      else $error("gain read does not show loop result");

   a_front_db: assert property (LNA_GAIN_DB == (LNA_GAIN_HIGH ? 5'd25 : 5'd5))
      else $error("front gain dB wrong");

   a_pga_db: assert property ((PGA_GAIN == 4'h1 |-> PGA_GAIN_DB == 5'd3)
      and (PGA_GAIN == 4'h5 |-> PGA_GAIN_DB == 5'd24))
      else $error("amplifier dB mapping wrong");

   a_ofs_read: assert property (s_read_ofs |=> REG_RDATA == $past(AFC_RESULT[7:0]))
      else $error("offset read not the correction result");

   a_ofs_hi_res: assert property ((REG_RD && REG_ADDR == mgmr_pkg::ADDR_OFS_HI)
      |=> REG_RDATA[7:2] == 6'h00 && REG_RDATA[1:0] == $past(AFC_RESULT[9:8]))
      else $error("upper offset read layout wrong");

   a_ph_pwdn: assert property ((mod_a[mgmr_pkg::MA_PHPWDN] && LOW_POWER_MODE)
      |=> PH_POWER_DOWN)
      else $error("packet handler not powered down");

   a_preamble_pol: assert property (TX_PREAMBLE_BIT |-> MANCH_EN)
      else $error("preamble polarity used without Manchester");

   a_dev_msb: assert property ((REG_WR && REG_ADDR == mgmr_pkg::ADDR_MOD_B)
      |=> deviation_setting[8] == $past(REG_WDATA[2]))
      else $error("deviation top bit not stored");

   a_mod_b_res: assert property ((REG_RD && REG_ADDR == mgmr_pkg::ADDR_MOD_B)
      |=> REG_RDATA[7:4] == 4'h0 && REG_RDATA[1:0] == 2'b00)
      else $error("reserved bits not zero");

   a_rate_reset: assert property ($rose(RST_B) |-> rate_lo == 8'h3D)
      else $error("rate low byte reset wrong");

   sequence s_write_mod_a;
      REG_WR && REG_ADDR == mgmr_pkg::ADDR_MOD_A;
   endsequence

   a_whiten_en: assert property (s_write_mod_a |=> ##1
      WHITEN_EN == $past(REG_WDATA[mgmr_pkg::MA_WHITE], 2))
      else $error("whitening enable not applied");

   a_manch_en: assert property (s_write_mod_a |=> ##1
      MANCH_EN == $past(REG_WDATA[mgmr_pkg::MA_MANCH], 2))
      else $error("Manchester enable not applied");

   a_manch_inv: assert property (s_write_mod_a |=> ##1
      MANCH_INV == ($past(REG_WDATA[mgmr_pkg::MA_MANCH], 2)
      && $past(REG_WDATA[mgmr_pkg::MA_MANINV], 2)))
      else $error("Manchester inversion not applied");

   a_rate_apply: assert property ((REG_WR && REG_ADDR == mgmr_pkg::ADDR_RATE_LO) |=> ##1
      DATA_RATE_LOW == $past(REG_WDATA, 2))
      else $error("data rate low byte not applied");

   a_ofs_store: assert property ((REG_WR && REG_ADDR == mgmr_pkg::ADDR_OFS_LO)
      |=> offset_setting[7:0] == $past(REG_WDATA))
      else $error("written offset not kept");

   a_ofs_sign: assert property (($past(RST_B) && !$past(BAND_HIGH)
      && $past(offset_setting) == 10'h3FF) |-> OFFSET_QHZ == -22'sd625)
      else $error("offset not two's complement");

   a_rssi_plain: assert property (!next_lna |=> RSSI_SMOOTH == $past(RSSI_IN))
      else $error("strength altered at low front gain");
endmodule // mgmr_regs
`default_nettype wire

// [sim/mgmr_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none
module mgmr_regs_test;
   logic REF_CLK, RST_B, REG_WR, REG_RD, AGC_TOO_HIGH, AGC_TOO_LOW, PREAMBLE_DET;
   logic BAND_HIGH, LOW_POWER_MODE, REG_RVALID, LNA_GAIN_HIGH;
   logic MANCH_EN, MANCH_INV, TX_PREAMBLE_BIT, WHITEN_EN, RX_DATA_INV, PH_POWER_DOWN;
   logic [6:0] REG_ADDR;
   logic [7:0] REG_WDATA, REG_RDATA, RSSI_IN, RSSI_SMOOTH, DATA_RATE_LOW;
   logic [9:0] AFC_RESULT;
   logic [3:0] PGA_GAIN;
   logic [4:0] LNA_GAIN_DB, PGA_GAIN_DB;
   logic [1:0] PGA_WINDOW_ADJ;
   logic [18:0] DEVIATION_HZ;
   logic signed [21:0] OFFSET_QHZ;
   int errors, n_checks, cycles, n;
   logic [4:0] g;
   logic [4:0] db_tab [6] = '{5'h00, 5'h03, 5'h06, 5'h0C, 5'h12, 5'h18};
   logic [7:0] mv [6] = '{8'hFF, 8'h1D, 8'h12, 8'h06, 8'h0A, 8'h01};

   mgmr_regs dut (.REF_CLK(REF_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
      .AGC_TOO_HIGH(AGC_TOO_HIGH), .AGC_TOO_LOW(AGC_TOO_LOW), .PREAMBLE_DET(PREAMBLE_DET),
      .RSSI_IN(RSSI_IN), .AFC_RESULT(AFC_RESULT), .BAND_HIGH(BAND_HIGH),
      .LOW_POWER_MODE(LOW_POWER_MODE), .LNA_GAIN_HIGH(LNA_GAIN_HIGH), .PGA_GAIN(PGA_GAIN),
      .LNA_GAIN_DB(LNA_GAIN_DB), .PGA_GAIN_DB(PGA_GAIN_DB), .PGA_WINDOW_ADJ(PGA_WINDOW_ADJ),
      .RSSI_SMOOTH(RSSI_SMOOTH), .DATA_RATE_LOW(DATA_RATE_LOW), .MANCH_EN(MANCH_EN),
      .MANCH_INV(MANCH_INV), .TX_PREAMBLE_BIT(TX_PREAMBLE_BIT), .WHITEN_EN(WHITEN_EN),
      .RX_DATA_INV(RX_DATA_INV), .PH_POWER_DOWN(PH_POWER_DOWN), .DEVIATION_HZ(DEVIATION_HZ),
      .OFFSET_QHZ(OFFSET_QHZ));

   initial begin
      REF_CLK = 1'b0;
      forever #12.5 REF_CLK = ~REF_CLK;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("unexpected at %0t: run too long", $time);
         final_report();
      end
   end

   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge REF_CLK);
      REG_ADDR <= a;
      REG_WDATA <= v;
      REG_WR <= 1'b1;
      @(posedge REF_CLK);
      REG_WR <= 1'b0;
   endtask

   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
      @(posedge REF_CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge REF_CLK);
      REG_RD <= 1'b0;
      #1;
      check(REG_RVALID, 1);
      check(REG_RDATA, exp);
   endtask

   task automatic settle();
      repeat (3) @(posedge REF_CLK);
      #1;
   endtask

   // cycles until the applied gain next changes
   task automatic wait_change(output int cnt);
      logic [4:0] start;
      start = {LNA_GAIN_HIGH, PGA_GAIN};
      cnt = 0;
      while ({LNA_GAIN_HIGH, PGA_GAIN} === start && cnt < 2000) begin
         @(posedge REF_CLK);
         #1;
         cnt++;
      end
   endtask

   function automatic logic [4:0] mod_exp(input logic [7:0] v, input logic lp);
      return {v[1], v[1] & v[2], v[1] & v[3], v[0], v[4] & lp};
   endfunction

   initial begin
      {RST_B, REG_WR, REG_RD, AGC_TOO_HIGH, AGC_TOO_LOW, PREAMBLE_DET} = '0;
      {BAND_HIGH, LOW_POWER_MODE, REG_ADDR, REG_WDATA} = '0;
      RSSI_IN = 8'h00;
      AFC_RESULT = 10'h2A5;
      repeat (5) @(posedge REF_CLK);
      RST_B <= 1'b1;
      settle();
      check(DATA_RATE_LOW, 8'h3D);
      check(DEVIATION_HZ, 32'd20000);
      check(LNA_GAIN_DB, 5'h19);
      check(OFFSET_QHZ, 0);
      rd_chk(mgmr_pkg::ADDR_GAIN_A, 8'h35);
      rd_chk(mgmr_pkg::ADDR_GAIN_B, 8'h00);
      rd_chk(mgmr_pkg::ADDR_RATE_LO, 8'h3D);
      rd_chk(mgmr_pkg::ADDR_MOD_A, 8'h00);
      rd_chk(mgmr_pkg::ADDR_MOD_B, 8'h00);
      rd_chk(mgmr_pkg::ADDR_DEV_LO, 8'h20);
      rd_chk(mgmr_pkg::ADDR_OFS_LO, 8'hA5);
      rd_chk(mgmr_pkg::ADDR_OFS_HI, 8'h02);
      $display("reset values done");
      // manual gain: both front selects and amplifier codes 0 to 5, reserved bits set
      for (int i = 0; i < 12; i++) begin
         wr(mgmr_pkg::ADDR_GAIN_A, 8'hC0 | 8'(i % 2) << 4 | 8'(i / 2));
         settle();
         check(LNA_GAIN_HIGH, i % 2);
         check(PGA_GAIN, i / 2);
         check(LNA_GAIN_DB, (i % 2) ? 5'h19 : 5'h05);
         check(PGA_GAIN_DB, db_tab[i / 2]);
         rd_chk(mgmr_pkg::ADDR_GAIN_A, 8'(i % 2) << 4 | 8'(i / 2));
      end
      $display("manual gain done");
      wr(mgmr_pkg::ADDR_GAIN_A, 8'h15);
      wr(mgmr_pkg::ADDR_GAIN_B, 8'h2B);
      RSSI_IN <= 8'h50;
      settle();
      check(RSSI_SMOOTH, 8'h46);
      check(PGA_WINDOW_ADJ, 2'h3);
      rd_chk(mgmr_pkg::ADDR_GAIN_B, 8'h2B);
      RSSI_IN <= 8'h05;
      settle();
      check(RSSI_SMOOTH, 8'h00);
      wr(mgmr_pkg::ADDR_GAIN_A, 8'h05);
      settle();
      check(RSSI_SMOOTH, 8'h05);
      $display("compensation done");
      // gain loop: drive to minimum, then time rises and falls
      wr(mgmr_pkg::ADDR_GAIN_B, 8'h00);
      wr(mgmr_pkg::ADDR_GAIN_A, 8'h20);
      AGC_TOO_HIGH <= 1'b1;
      repeat (600) @(posedge REF_CLK);
      #1;
      check({LNA_GAIN_HIGH, PGA_GAIN}, 5'h00);
      rd_chk(mgmr_pkg::ADDR_GAIN_A, 8'h20);
      AGC_TOO_HIGH <= 1'b0;
      AGC_TOO_LOW <= 1'b1;
      wait_change(n);
      wait_change(n);
      check(n, 40);
      wr(mgmr_pkg::ADDR_GAIN_B, 8'h40);
      wait_change(n);
      wait_change(n);
      check(n, 320);
      AGC_TOO_LOW <= 1'b0;
      AGC_TOO_HIGH <= 1'b1;
      wait_change(n);
      wait_change(n);
      check(n, 40);
      PREAMBLE_DET <= 1'b1;
      repeat (5) @(posedge REF_CLK);
      #1;
      g = {LNA_GAIN_HIGH, PGA_GAIN};
      repeat (200) @(posedge REF_CLK);
      #1;
      check({LNA_GAIN_HIGH, PGA_GAIN}, g);
      wr(mgmr_pkg::ADDR_GAIN_B, 8'h80);
      wait_change(n);
      check(n < 50, 1);
      PREAMBLE_DET <= 1'b0;
      AGC_TOO_HIGH <= 1'b0;
      $display("gain loop done");
      for (int i = 0; i < 6; i++) begin
         @(posedge REF_CLK);
         LOW_POWER_MODE <= i[0];
         wr(mgmr_pkg::ADDR_MOD_A, mv[i]);
         settle();
         check({MANCH_EN, MANCH_INV, TX_PREAMBLE_BIT, WHITEN_EN, PH_POWER_DOWN},
            mod_exp(mv[i], i[0]));
         rd_chk(mgmr_pkg::ADDR_MOD_A, mv[i] & 8'h3F);
      end
      $display("modulation control done");
      wr(mgmr_pkg::ADDR_MOD_B, 8'hFF);
      wr(mgmr_pkg::ADDR_DEV_LO, 8'hFF);
      settle();
      check(DEVIATION_HZ, 625 * 511);
      check(RX_DATA_INV, 1);
      rd_chk(mgmr_pkg::ADDR_MOD_B, 8'h0C);
      wr(mgmr_pkg::ADDR_MOD_B, 8'h04);
      wr(mgmr_pkg::ADDR_DEV_LO, 8'h00);
      settle();
      check(DEVIATION_HZ, 625 * 256);
      $display("deviation done");
      wr(mgmr_pkg::ADDR_OFS_LO, 8'hFF);
      wr(mgmr_pkg::ADDR_OFS_HI, 8'hFF);
      settle();
      check(OFFSET_QHZ, -625);
      BAND_HIGH <= 1'b1;
      settle();
      check(OFFSET_QHZ, -1250);
      rd_chk(mgmr_pkg::ADDR_OFS_LO, 8'hA5);
      AFC_RESULT <= 10'h15A;
      rd_chk(mgmr_pkg::ADDR_OFS_LO, 8'h5A);
      rd_chk(mgmr_pkg::ADDR_OFS_HI, 8'h01);
      wr(mgmr_pkg::ADDR_OFS_HI, 8'hFD);
      settle();
      check(OFFSET_QHZ, 1250 * 511);
      wr(mgmr_pkg::ADDR_OFS_LO, 8'h01);
      wr(mgmr_pkg::ADDR_OFS_HI, 8'h00);
      settle();
      check(OFFSET_QHZ, 1250);
      $display("offset done");
      wr(mgmr_pkg::ADDR_RATE_LO, 8'hA7);
      rd_chk(mgmr_pkg::ADDR_RATE_LO, 8'hA7);
      settle();
      check(DATA_RATE_LOW, 8'hA7);
      wr(7'h75, 8'hFF);
      rd_chk(7'h75, 8'h00);
      rd_chk(7'h68, 8'h00);
      $display("data rate and unmapped done");
      final_report();
   end
endmodule // mgmr_regs_test
`default_nettype wire
